// ---- pkg/ppcrb_regs.svh ----
`ifndef PPCRB_REGS_SVH
`define PPCRB_REGS_SVH
`define PPCRB_CMD_TEMP_LAST 8'h07
`define PPCRB_CMD_MAX 8'h08
`define PPCRB_CMD_FWVER 8'h09
`define PPCRB_CMD_MAXSRC 8'h0a
`define PPCRB_CMD_ALSRC 8'h0b
`define PPCRB_CMD_CFG0 8'h0c
`define PPCRB_CMD_CFG1 8'h0d
`define PPCRB_CMD_OFFS 8'h0e
`define PPCRB_CMD_AVG 8'h0f
`define PPCRB_CMD_THR_FIRST 8'h10
`define PPCRB_CMD_THR_LAST 8'h13
`define PPCRB_CMD_POLLREQ 8'h14
`define PPCRB_CMD_ALCLR 8'h15
`define PPCRB_CFG0_EN_LO 8
`define PPCRB_CFG0_TMO 7
`define PPCRB_CFG0_ALT 6
`define PPCRB_CFG0_PEC 5
`define PPCRB_CFG0_MASK 4
`define PPCRB_CFG0_DLY_HI 2
`define PPCRB_CFG0_WMASK 16'hfff7
`define PPCRB_CFG0_RST 16'h00a5
`define PPCRB_CFG1_RST 16'h0203
`define PPCRB_OFFS_RST 16'h0000
`define PPCRB_AVG_RST 16'h0000
`define PPCRB_AVG_WMASK 16'h00ff
`define PPCRB_AVG_MAX_SHIFT 16
`define PPCRB_THR_RST 16'h7fff
`define PPCRB_TEMP_RST 16'h0000
`define PPCRB_ERR_TOP 7'h40
`define PPCRB_ALT_SHIFT 6
`define PPCRB_ALSRC_PEND 8
`define PPCRB_ENTRIES 8
`define PPCRB_SOCKETS 4
`define PPCRB_CLK_MHZ 100
`define PPCRB_T_GAP_US 2500
`define PPCRB_T_D1_US 2500
`define PPCRB_T_D2_US 5000
`define PPCRB_T_D3_US 10000
`define PPCRB_T_D4_US 50000
`define PPCRB_T_D5_US 100000
`define PPCRB_T_D6_US 500000
`define PPCRB_FWVER_DEF 16'h0100
`endif

// ---- pkg/ppcrb_pkg.sv ----
package ppcrb_pkg;
	typedef enum logic [1:0]
	{
		PPCRB_KIND_READ = 2'b00,
		PPCRB_KIND_WRITE = 2'b01,
		PPCRB_KIND_SEND = 2'b10
	} ppcrb_kind_t;
	typedef enum logic [1:0]
	{
		PPCRB_ST_IDLE = 2'b00,
		PPCRB_ST_GAP = 2'b01,
		PPCRB_ST_WAIT = 2'b10,
		PPCRB_ST_PAUSE = 2'b11
	} ppcrb_poll_st_t;
endpackage : ppcrb_pkg

// ---- pkg/ppcrb_poll_if.sv ----
`timescale 1ns/100ps
interface ppcrb_poll_if;
	logic req_tgl;
	logic [2:0] idx;
	logic ack_tgl;
	logic [15:0] data;
	modport core (output req_tgl, output idx, input ack_tgl, input data);
	modport link (input req_tgl, input idx, output ack_tgl, output data);
endinterface : ppcrb_poll_if

// ---- rtl/ppcrb_result_fmt.sv ----
`timescale 1ns/100ps
`include "ppcrb_regs.svh"
module ppcrb_result_fmt
(
	input wire logic [15:0] raw,
	input wire logic [15:0] offset,
	input wire logic alt_fmt,
	output logic [15:0] value,
	output logic is_err
);
	logic [15:0] scaled;
	always_comb
	begin
		is_err = (raw[15:9] == `PPCRB_ERR_TOP);
		scaled = alt_fmt ? 16'($signed(raw) >>> `PPCRB_ALT_SHIFT) : raw;
		value = is_err ? raw : 16'(scaled + offset);
	end
endmodule : ppcrb_result_fmt

// ---- rtl/ppcrb_link_port.sv ----
`timescale 1ns/100ps
module ppcrb_link_port
(
	input wire logic peci_clk,
	input wire logic rst_n,
	ppcrb_poll_if.link poll,
	output logic link_req_q,
	output logic [2:0] link_target_q,
	input wire logic link_done,
	input wire logic [15:0] link_data
);
	logic rst_meta_q;
	logic rst_sync_q;
	logic req_meta_q;
	logic req_sync_q;
	logic seen_q;
	logic seen_d;
	logic ack_q;
	logic ack_d;
	logic link_req_d;
	logic [2:0] target_d;
	logic [15:0] data_q;
	logic [15:0] data_d;
	// Reset and request toggle both arrive from the core clock
	always_ff @(posedge peci_clk)
	begin
		rst_meta_q <= rst_n;
		rst_sync_q <= rst_meta_q;
		req_meta_q <= poll.req_tgl;
		req_sync_q <= req_meta_q;
	end
	// Index is held by the core until the answer toggles back
	always_comb
	begin
		seen_d = seen_q;
		ack_d = ack_q;
		link_req_d = link_req_q;
		target_d = link_target_q;
		data_d = data_q;
		if (!link_req_q && (req_sync_q != seen_q))
		begin
			link_req_d = 1'b1;
			target_d = poll.idx;
			seen_d = req_sync_q;
		end
		else if (link_req_q && link_done)
		begin
			link_req_d = 1'b0;
			data_d = link_data;
			ack_d = ~ack_q;
		end
	end
	always_ff @(posedge peci_clk)
	begin
		if (!rst_sync_q)
		begin
			seen_q <= 1'b0;
			ack_q <= 1'b0;
			link_req_q <= 1'b0;
			link_target_q <= 3'h0;
			data_q <= 16'h0000;
		end
		else
		begin
			seen_q <= seen_d;
			ack_q <= ack_d;
			link_req_q <= link_req_d;
			link_target_q <= target_d;
			data_q <= data_d;
		end
	end
	assign poll.ack_tgl = ack_q;
	assign poll.data = data_q;
endmodule : ppcrb_link_port

// ---- rtl/ppcrb_top.sv ----
`timescale 1ns/100ps
`include "ppcrb_regs.svh"
module ppcrb_top
#(
	parameter int unsigned GAP_CYC = `PPCRB_T_GAP_US * `PPCRB_CLK_MHZ,
	parameter int unsigned DLY1_CYC = `PPCRB_T_D1_US * `PPCRB_CLK_MHZ,
	parameter int unsigned DLY2_CYC = `PPCRB_T_D2_US * `PPCRB_CLK_MHZ,
	parameter int unsigned DLY3_CYC = `PPCRB_T_D3_US * `PPCRB_CLK_MHZ,
	parameter int unsigned DLY4_CYC = `PPCRB_T_D4_US * `PPCRB_CLK_MHZ,
	parameter int unsigned DLY5_CYC = `PPCRB_T_D5_US * `PPCRB_CLK_MHZ,
	parameter int unsigned DLY6_CYC = `PPCRB_T_D6_US * `PPCRB_CLK_MHZ,
	// Arbitrary value
	parameter logic [15:0] FW_VERSION = `PPCRB_FWVER_DEF
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic host_valid,
	input wire ppcrb_pkg::ppcrb_kind_t host_kind,
	input wire logic [7:0] host_cmd,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata_q,
	output logic host_rvalid_q,
	output logic alert_q,
	output logic lockup_timeout_en_q,
	output logic pec_en_q,
	output logic [7:0] peci_bit_time_q,
	output logic [7:0] peci_retry_limit_q,
	input wire logic peci_clk,
	output logic link_req_q,
	output logic [2:0] link_target_q,
	input wire logic link_done,
	input wire logic [15:0] link_data
);
	ppcrb_poll_if poll ();
	logic [15:0] cfg0_q;
	logic [15:0] cfg0_d;
	logic [15:0] cfg1_q;
	logic [15:0] cfg1_d;
	logic [15:0] offs_q;
	logic [15:0] offs_d;
	logic [15:0] avg_q;
	logic [15:0] avg_d;
	logic [15:0] thr_q [`PPCRB_SOCKETS];
	logic [15:0] thr_d [`PPCRB_SOCKETS];
	logic [15:0] temp_q [`PPCRB_ENTRIES];
	logic [15:0] temp_d [`PPCRB_ENTRIES];
	logic [15:0] fmt_val [`PPCRB_ENTRIES];
	logic [`PPCRB_ENTRIES-1:0] fmt_err;
	logic [`PPCRB_ENTRIES-1:0] en;
	logic [`PPCRB_CFG0_DLY_HI:0] dly_sel;
	logic is_rd;
	logic is_wr;
	logic poll_req;
	logic alert_clr;
	ppcrb_pkg::ppcrb_poll_st_t st_q;
	ppcrb_pkg::ppcrb_poll_st_t st_d;
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic [31:0] dly_cyc;
	logic [31:0] hold_cyc;
	logic [2:0] idx_q;
	logic [2:0] idx_d;
	logic tgl_q;
	logic tgl_d;
	logic pend_q;
	logic pend_d;
	logic [3:0] hit;
	logic ack_meta_q;
	logic ack_sync_q;
	logic ack_seen_q;
	logic ack_evt;
	logic [15:0] old_w;
	logic [15:0] avg_word;
	logic signed [16:0] diff;
	logic signed [16:0] step;
	logic [4:0] shamt;
	logic [15:0] max_val_q;
	logic [15:0] max_val_d;
	logic [2:0] max_src_q;
	logic [2:0] max_src_d;
	logic max_found;
	logic chk_q;
	logic [2:0] chk_idx_q;
	logic alert_hit;
	logic alert_d;
	logic [2:0] alsrc_q;
	logic [2:0] alsrc_d;
	logic [15:0] rd_word;

	function automatic logic [3:0] next_en(input logic [7:0] mask, input logic [3:0] from);
		logic [3:0] res;
		res = 4'h0;
		for (int i = `PPCRB_ENTRIES - 1; i >= 0; i--)
		begin
			if ((i >= int'(from)) && mask[i])
			begin
				res = {1'b1, 3'(i)};
			end
		end
		return res;
	endfunction : next_en

	assign is_rd = host_valid && (host_kind == ppcrb_pkg::PPCRB_KIND_READ);
	assign is_wr = host_valid && (host_kind == ppcrb_pkg::PPCRB_KIND_WRITE);
	assign poll_req = host_valid && (host_kind == ppcrb_pkg::PPCRB_KIND_SEND)
		&& (host_cmd == `PPCRB_CMD_POLLREQ);
	assign alert_clr = host_valid && (host_kind == ppcrb_pkg::PPCRB_KIND_SEND)
		&& (host_cmd == `PPCRB_CMD_ALCLR);
	assign en = cfg0_q[15:`PPCRB_CFG0_EN_LO];
	assign dly_sel = cfg0_q[`PPCRB_CFG0_DLY_HI:0];
	assign lockup_timeout_en_q = cfg0_q[`PPCRB_CFG0_TMO];
	assign pec_en_q = cfg0_q[`PPCRB_CFG0_PEC];
	assign peci_bit_time_q = cfg1_q[15:8];
	assign peci_retry_limit_q = cfg1_q[7:0];

	always_comb
	begin
		unique case (dly_sel)
			3'h1: dly_cyc = DLY1_CYC;
			3'h2: dly_cyc = DLY2_CYC;
			3'h3: dly_cyc = DLY3_CYC;
			3'h4: dly_cyc = DLY4_CYC;
			3'h5: dly_cyc = DLY5_CYC;
			3'h6: dly_cyc = DLY6_CYC;
			// Reserved code behaves as request-only
			default: dly_cyc = 32'h0000_0000;
		endcase
		// Request-only mode still keeps the read spacing across rounds
		hold_cyc = (dly_cyc == 32'h0000_0000) ? GAP_CYC : dly_cyc;
	end

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		idx_d = idx_q;
		tgl_d = tgl_q;
		pend_d = pend_q | poll_req;
		hit = 4'h0;
		unique case (st_q)
			ppcrb_pkg::PPCRB_ST_IDLE:
			begin
				if (pend_q || (dly_cyc != 32'h0000_0000))
				begin
					pend_d = poll_req;
					hit = next_en(en, 4'h0);
					if (hit[3])
					begin
						idx_d = hit[2:0];
						tgl_d = ~tgl_q;
						st_d = ppcrb_pkg::PPCRB_ST_WAIT;
					end
					else
					begin
						st_d = ppcrb_pkg::PPCRB_ST_PAUSE;
						cnt_d = hold_cyc - 32'd1;
					end
				end
			end
			ppcrb_pkg::PPCRB_ST_WAIT:
			begin
				if (ack_evt)
				begin
					hit = next_en(en, 4'({1'b0, idx_q} + 4'd1));
					if (hit[3])
					begin
						idx_d = hit[2:0];
						st_d = ppcrb_pkg::PPCRB_ST_GAP;
						cnt_d = GAP_CYC - 32'd1;
					end
					else
					begin
						st_d = ppcrb_pkg::PPCRB_ST_PAUSE;
						cnt_d = hold_cyc - 32'd1;
					end
				end
			end
			ppcrb_pkg::PPCRB_ST_GAP:
			begin
				if (cnt_q == 32'h0000_0000)
				begin
					tgl_d = ~tgl_q;
					st_d = ppcrb_pkg::PPCRB_ST_WAIT;
				end
				else
				begin
					cnt_d = cnt_q - 32'd1;
				end
			end
			ppcrb_pkg::PPCRB_ST_PAUSE:
			begin
				if (cnt_q == 32'h0000_0000)
				begin
					st_d = ppcrb_pkg::PPCRB_ST_IDLE;
				end
				else
				begin
					cnt_d = cnt_q - 32'd1;
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_q <= ppcrb_pkg::PPCRB_ST_IDLE;
			cnt_q <= 32'h0000_0000;
			idx_q <= 3'h0;
			tgl_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			tgl_q <= tgl_d;
			pend_q <= pend_d;
		end
	end
	assign poll.req_tgl = tgl_q;
	assign poll.idx = idx_q;

	// Answer toggle crosses back; the data word is stable once it shows
	always_ff @(posedge clk)
	begin
		ack_meta_q <= poll.ack_tgl;
		ack_sync_q <= ack_meta_q;
		if (!rst_n)
		begin
			ack_seen_q <= 1'b0;
		end
		else
		begin
			ack_seen_q <= ack_sync_q;
		end
	end
	assign ack_evt = (ack_sync_q != ack_seen_q);

	// Averaging trades resolution for noise; low bits may be lost
	always_comb
	begin
		old_w = temp_q[idx_q];
		shamt = (avg_q[7:0] > 8'(`PPCRB_AVG_MAX_SHIFT)) ? 5'(`PPCRB_AVG_MAX_SHIFT) : avg_q[4:0];
		diff = $signed({poll.data[15], poll.data}) - $signed({old_w[15], old_w});
		step = diff >>> shamt;
		avg_word = poll.data;
		if ((avg_q[7:0] != 8'h00) && (poll.data[15:9] != `PPCRB_ERR_TOP)
			&& (old_w[15:9] != `PPCRB_ERR_TOP))
		begin
			avg_word = 16'($signed(old_w) + step[15:0]);
		end
	end

	for (genvar g = 0; g < `PPCRB_ENTRIES; g++)
	begin : g_entry
		always_comb
		begin
			temp_d[g] = temp_q[g];
			if (ack_evt && (idx_q == 3'(g)))
			begin
				temp_d[g] = avg_word;
			end
		end
		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				temp_q[g] <= `PPCRB_TEMP_RST;
			end
			else
			begin
				temp_q[g] <= temp_d[g];
			end
		end
		ppcrb_result_fmt u_fmt
		(
			.raw(temp_q[g]),
			.offset(offs_q),
			.alt_fmt(cfg0_q[`PPCRB_CFG0_ALT]),
			.value(fmt_val[g]),
			.is_err(fmt_err[g])
		);
	end

	always_comb
	begin
		max_val_d = 16'h0000;
		max_src_d = 3'h0;
		max_found = 1'b0;
		for (int i = 0; i < `PPCRB_ENTRIES; i++)
		begin
			if (en[i] && !fmt_err[i]
				&& (!max_found || ($signed(fmt_val[i]) > $signed(max_val_d))))
			begin
				max_val_d = fmt_val[i];
				max_src_d = 3'(i);
				max_found = 1'b1;
			end
		end
	end

	always_comb
	begin
		alert_hit = chk_q && !cfg0_q[`PPCRB_CFG0_MASK] && !fmt_err[chk_idx_q]
			&& ($signed(fmt_val[chk_idx_q]) > $signed(thr_q[chk_idx_q[2:1]]));
		alert_d = alert_hit | (alert_q & ~alert_clr);
		alsrc_d = alert_hit ? chk_idx_q : alsrc_q;
	end

	always_comb
	begin
		cfg0_d = cfg0_q;
		cfg1_d = cfg1_q;
		offs_d = offs_q;
		avg_d = avg_q;
		thr_d = thr_q;
		if (is_wr)
		begin
			unique case (host_cmd)
				`PPCRB_CMD_CFG0:
				begin
					cfg0_d = host_wdata & `PPCRB_CFG0_WMASK;
					// keep offset meaning on format change
					if (host_wdata[`PPCRB_CFG0_ALT] && !cfg0_q[`PPCRB_CFG0_ALT])
					begin
						offs_d = 16'($signed(offs_q) >>> `PPCRB_ALT_SHIFT);
					end
					else if (!host_wdata[`PPCRB_CFG0_ALT] && cfg0_q[`PPCRB_CFG0_ALT])
					begin
						offs_d = 16'(offs_q << `PPCRB_ALT_SHIFT);
					end
				end
				`PPCRB_CMD_CFG1: cfg1_d = host_wdata;
				`PPCRB_CMD_OFFS: offs_d = host_wdata;
				`PPCRB_CMD_AVG: avg_d = host_wdata & `PPCRB_AVG_WMASK;
				8'h10, 8'h11, 8'h12, 8'h13: thr_d[host_cmd[1:0]] = host_wdata;
				default: cfg0_d = cfg0_q;
			endcase
		end
	end

	always_comb
	begin
		rd_word = 16'h0000;
		if (host_cmd <= `PPCRB_CMD_TEMP_LAST)
		begin
			rd_word = fmt_val[host_cmd[2:0]];
		end
		else if (host_cmd == `PPCRB_CMD_MAX)
		begin
			rd_word = max_val_q;
		end
		else if (host_cmd == `PPCRB_CMD_FWVER)
		begin
			rd_word = FW_VERSION;
		end
		else if (host_cmd == `PPCRB_CMD_MAXSRC)
		begin
			rd_word = {13'h0000, max_src_q};
		end
		else if (host_cmd == `PPCRB_CMD_ALSRC)
		begin
			rd_word = {7'h00, alert_q, 5'h00, alsrc_q};
		end
		else if (host_cmd == `PPCRB_CMD_CFG0)
		begin
			rd_word = cfg0_q;
		end
		else if (host_cmd == `PPCRB_CMD_CFG1)
		begin
			rd_word = cfg1_q;
		end
		else if (host_cmd == `PPCRB_CMD_OFFS)
		begin
			rd_word = offs_q;
		end
		else if (host_cmd == `PPCRB_CMD_AVG)
		begin
			rd_word = avg_q;
		end
		else if ((host_cmd >= `PPCRB_CMD_THR_FIRST) && (host_cmd <= `PPCRB_CMD_THR_LAST))
		begin
			rd_word = thr_q[host_cmd[1:0]];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg0_q <= `PPCRB_CFG0_RST;
			cfg1_q <= `PPCRB_CFG1_RST;
			offs_q <= `PPCRB_OFFS_RST;
			avg_q <= `PPCRB_AVG_RST;
			thr_q <= '{default: `PPCRB_THR_RST};
			max_val_q <= 16'h0000;
			max_src_q <= 3'h0;
			chk_q <= 1'b0;
			chk_idx_q <= 3'h0;
			alert_q <= 1'b0;
			alsrc_q <= 3'h0;
			host_rdata_q <= 16'h0000;
			host_rvalid_q <= 1'b0;
		end
		else
		begin
			cfg0_q <= cfg0_d;
			cfg1_q <= cfg1_d;
			offs_q <= offs_d;
			avg_q <= avg_d;
			thr_q <= thr_d;
			max_val_q <= max_val_d;
			max_src_q <= max_src_d;
			chk_q <= ack_evt;
			chk_idx_q <= idx_q;
			alert_q <= alert_d;
			alsrc_q <= alsrc_d;
			host_rdata_q <= is_rd ? rd_word : host_rdata_q;
			host_rvalid_q <= is_rd;
		end
	end

	ppcrb_link_port u_link
	(
		.peci_clk(peci_clk),
		.rst_n(rst_n),
		.poll(poll.link),
		.link_req_q(link_req_q),
		.link_target_q(link_target_q),
		.link_done(link_done),
		.link_data(link_data)
	);
endmodule : ppcrb_top

// ---- tb/ppcrb_monitor.sv ----
`timescale 1ns/100ps
module ppcrb_monitor
#(
	parameter logic [15:0] FW_VERSION = 16'h0100
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic host_valid,
	input wire ppcrb_pkg::ppcrb_kind_t host_kind,
	input wire logic [7:0] host_cmd,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata_q,
	input wire logic host_rvalid_q,
	input wire logic alert_q,
	input wire logic lockup_timeout_en_q,
	input wire logic pec_en_q,
	input wire logic [7:0] peci_bit_time_q,
	input wire logic [7:0] peci_retry_limit_q,
	input wire logic peci_clk,
	input wire logic link_req_q,
	input wire logic [2:0] link_target_q,
	input wire logic link_done
);
	logic rd_c;
	logic wr_c;
	logic clr_c;
	assign rd_c = host_valid && host_kind == ppcrb_pkg::PPCRB_KIND_READ;
	assign wr_c = host_valid && host_kind == ppcrb_pkg::PPCRB_KIND_WRITE;
	assign clr_c = host_valid && host_kind == ppcrb_pkg::PPCRB_KIND_SEND && host_cmd == 8'h15;
	a_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
		rd_c |=> host_rvalid_q)
		else $error("read not answered");
	a_no_spurious: assert property (@(posedge clk) disable iff (!rst_n)
		!rd_c |=> !host_rvalid_q)
		else $error("answer without read");
	a_fw_word: assert property (@(posedge clk) disable iff (!rst_n)
		rd_c && host_cmd == 8'h09 |=> host_rdata_q == FW_VERSION)
		else $error("version word wrong");
	a_unknown_zero: assert property (@(posedge clk) disable iff (!rst_n)
		rd_c && host_cmd > 8'h13 |=> host_rdata_q == 16'h0000)
		else $error("unknown code not zero");
	a_cfg_back: assert property (@(posedge clk) disable iff (!rst_n)
		wr_c && host_cmd == 8'h0c ##1 rd_c && host_cmd == 8'h0c
		|=> host_rdata_q == ($past(host_wdata, 2) & 16'hfff7))
		else $error("main config readback wrong");
	a_cfg_pins: assert property (@(posedge clk) disable iff (!rst_n)
		wr_c && host_cmd == 8'h0c |=> lockup_timeout_en_q == $past(host_wdata[7])
		&& pec_en_q == $past(host_wdata[5]))
		else $error("config pins wrong");
	a_cfg1_pins: assert property (@(posedge clk) disable iff (!rst_n)
		wr_c && host_cmd == 8'h0d
		|=> {peci_bit_time_q, peci_retry_limit_q} == $past(host_wdata))
		else $error("retry word pins wrong");
	a_alert_hold: assert property (@(posedge clk) disable iff (!rst_n)
		alert_q && !clr_c |=> alert_q)
		else $error("alert dropped");
	a_reset_pins: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> lockup_timeout_en_q && pec_en_q &&
		peci_bit_time_q == 8'h02 && peci_retry_limit_q == 8'h03)
		else $error("reset pins wrong");
	a_link_hold: assert property (@(posedge peci_clk) disable iff (!rst_n)
		link_req_q && !link_done |=> link_req_q && $stable(link_target_q))
		else $error("link request unstable");
	a_link_drop: assert property (@(posedge peci_clk) disable iff (!rst_n)
		link_req_q && link_done |=> !link_req_q)
		else $error("link request held");
	cover property (@(posedge clk) rd_c ##1 host_rvalid_q);
	cover property (@(posedge clk) $rose(alert_q));
	cover property (@(posedge peci_clk) link_req_q && link_done);
endmodule : ppcrb_monitor
bind ppcrb_top ppcrb_monitor #(.FW_VERSION(FW_VERSION)) ppcrb_monitor_i (.clk(clk), .rst_n(rst_n),
	.host_valid(host_valid), .host_kind(host_kind), .host_cmd(host_cmd), .host_wdata(host_wdata),
	.host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q), .alert_q(alert_q),
	.lockup_timeout_en_q(lockup_timeout_en_q), .pec_en_q(pec_en_q),
	.peci_bit_time_q(peci_bit_time_q), .peci_retry_limit_q(peci_retry_limit_q),
	.peci_clk(peci_clk), .link_req_q(link_req_q), .link_target_q(link_target_q),
	.link_done(link_done));

// ---- tb/ppcrb_peci_model.sv ----
`timescale 1ns/100ps
module ppcrb_peci_model
(
	input wire logic peci_clk,
	input wire logic link_req_q,
	input wire logic [2:0] link_target_q,
	input wire logic [127:0] temps,
	output logic link_done,
	output logic [15:0] link_data,
	output int served
);
	int wait_q = 2;
	initial link_done = 1'b0;
	initial link_data = 16'h0000;
	initial served = 0;
	// Latency varies from two to four cycles so slow and prompt answers both occur
	always @(posedge peci_clk)
	begin
		link_done <= 1'b0;
		link_data <= ~link_data;
		// Request is still unknown until reset reaches the link; never serve it then
		if (link_req_q !== 1'b1 || link_done)
			wait_q <= 1 + served % 3;
		else if (wait_q == 0)
		begin
			link_done <= 1'b1;
			link_data <= temps[link_target_q * 16 +: 16];
			served <= served + 1;
		end
		else
			wait_q <= wait_q - 1;
	end
endmodule : ppcrb_peci_model

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	logic clk = 1'b0;
	logic peci_clk = 1'b0;
	logic rst_n;
	logic host_valid;
	ppcrb_pkg::ppcrb_kind_t host_kind;
	logic [7:0] host_cmd;
	logic [15:0] host_wdata;
	logic [15:0] host_rdata_q;
	logic host_rvalid_q;
	logic alert_q;
	logic lockup_timeout_en_q;
	logic pec_en_q;
	logic [7:0] peci_bit_time_q;
	logic [7:0] peci_retry_limit_q;
	logic link_req_q;
	logic [2:0] link_target_q;
	logic link_done;
	logic [15:0] link_data;
	logic [127:0] temps;
	logic [15:0] exp_q [$];
	logic [7:0] cmd_q [$];
	logic [15:0] r;
	logic [15:0] e;
	logic [7:0] c;
	int served;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int gap = 0;
	int last_gap = 0;
	logic req_was = 1'b0;
	always #5 clk = ~clk;
	always #40 peci_clk = ~peci_clk;
	ppcrb_top #(.GAP_CYC(200), .DLY1_CYC(300), .DLY5_CYC(100)) ppcrb_top_i (.clk(clk),
		.rst_n(rst_n),
		.host_valid(host_valid), .host_kind(host_kind), .host_cmd(host_cmd),
		.host_wdata(host_wdata), .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q),
		.alert_q(alert_q), .lockup_timeout_en_q(lockup_timeout_en_q), .pec_en_q(pec_en_q),
		.peci_bit_time_q(peci_bit_time_q), .peci_retry_limit_q(peci_retry_limit_q),
		.peci_clk(peci_clk), .link_req_q(link_req_q), .link_target_q(link_target_q),
		.link_done(link_done), .link_data(link_data));
	ppcrb_peci_model ppcrb_peci_model_i (.peci_clk(peci_clk), .link_req_q(link_req_q),
		.link_target_q(link_target_q), .temps(temps), .link_done(link_done),
		.link_data(link_data), .served(served));
	task automatic op(input ppcrb_pkg::ppcrb_kind_t k, input logic [7:0] cm, input logic [15:0] d);
		@(posedge clk);
		#1;
		host_valid = 1'b1;
		host_kind = k;
		host_cmd = cm;
		host_wdata = d;
	endtask : op
	task automatic rd(input logic [7:0] cm, input logic [15:0] ex);
		op(ppcrb_pkg::PPCRB_KIND_READ, cm, 16'h0000);
		exp_q.push_back(ex);
		cmd_q.push_back(cm);
	endtask : rd
	task automatic wr(input logic [7:0] cm, input logic [15:0] d);
		op(ppcrb_pkg::PPCRB_KIND_WRITE, cm, d);
	endtask : wr
	task automatic idle();
		@(posedge clk);
		#1;
		host_valid = 1'b0;
		repeat (3) @(posedge clk);
	endtask : idle
	task automatic wait_poll(input int n);
		for (int i = 0; i < 3000 && served < n; i++)
			@(posedge clk);
		if (served < n)
		begin
			fails++;
			give_verdict();
		end
		repeat (30) @(posedge clk);
	endtask : wait_poll
	task automatic give_verdict();
		if (exp_q.size() != 0)
			fails++;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	always @(negedge clk)
	begin
		if (host_rvalid_q === 1'b1 && exp_q.size() == 0)
			`CHK("spare answer", 1'b0, 1'b1)
		else if (host_rvalid_q === 1'b1)
		begin
			e = exp_q.pop_front();
			c = cmd_q.pop_front();
			`CHK($sformatf("cmd %h", c), e, host_rdata_q)
		end
	end
	// Clock cycles between rising link requests
	always @(posedge clk)
	begin
		gap++;
		if (link_req_q === 1'b1 && !req_was)
		begin
			last_gap = gap;
			gap = 0;
		end
		req_was = (link_req_q === 1'b1);
	end
	// Whole run needs about 2000 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			give_verdict();
		end
	end
	initial
	begin
		host_valid = 1'b0;
		host_kind = ppcrb_pkg::PPCRB_KIND_READ;
		host_cmd = 8'h00;
		host_wdata = 16'h0000;
		temps = '0;
		temps[15:0] = 16'hffc0;
		temps[63:48] = 16'h8005;
		rst_n = 1'b0;
		// Link side leaves reset later, through two of its own flops
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		void'($urandom(32'hab4a));
		rd(8'h0c, 16'h00a5);
		rd(8'h0d, 16'h0203);
		rd(8'h0e, 16'h0000);
		rd(8'h0f, 16'h0000);
		for (int i = 0; i < 8; i++)
			rd(i[7:0], 16'h0000);
		for (int i = 16; i < 20; i++)
			rd(i[7:0], 16'h7fff);
		rd(8'h09, 16'h0100);
		idle();
		`CHK("timeout_en", 1'b1, lockup_timeout_en_q)
		`CHK("pec_en", 1'b1, pec_en_q)
		`CHK("bit_time", 8'h02, peci_bit_time_q)
		$display("test reset done");
		for (int i = 16; i < 20; i++)
		begin
			r = $urandom;
			r[15] = 1'b0;
			wr(i[7:0], r);
			rd(i[7:0], r);
		end
		r = $urandom;
		wr(8'h0f, r);
		rd(8'h0f, r & 16'h00ff);
		wr(8'h0c, 16'h00ad);
		rd(8'h0c, 16'h00a5);
		wr(8'h0d, 16'h1403);
		rd(8'h0d, 16'h1403);
		wr(8'h20, r);
		rd(8'h20, 16'h0000);
		wr(8'h09, r);
		rd(8'h09, 16'h0100);
		rd(8'h14, 16'h0000);
		wr(8'h0f, 16'h0000);
		wr(8'h0c, 16'h0900);
		idle();
		repeat (300) @(posedge clk);
		`CHK("served", 0, served)
		$display("test registers done");
		op(ppcrb_pkg::PPCRB_KIND_SEND, 8'h14, 16'h0000);
		idle();
		wait_poll(2);
		`CHK("read spacing", 1'b1, (last_gap >= 200 && last_gap <= 320))
		rd(8'h00, 16'hffc0);
		rd(8'h03, 16'h8005);
		rd(8'h08, 16'hffc0);
		rd(8'h0a, 16'h0000);
		wr(8'h0e, 16'h17c0);
		rd(8'h00, 16'h1780);
		rd(8'h03, 16'h8005);
		wr(8'h0c, 16'h0940);
		rd(8'h0e, 16'h005f);
		rd(8'h00, 16'h005e);
		idle();
		$display("test poll done");
		temps[15:0] = 16'hff80;
		wr(8'h10, 16'h0000);
		op(ppcrb_pkg::PPCRB_KIND_SEND, 8'h14, 16'h0000);
		idle();
		wait_poll(4);
		rd(8'h00, 16'h005d);
		rd(8'h08, 16'h005d);
		rd(8'h0b, 16'h0100);
		idle();
		`CHK("alert", 1'b1, alert_q)
		op(ppcrb_pkg::PPCRB_KIND_SEND, 8'h15, 16'h0000);
		idle();
		`CHK("alert", 1'b0, alert_q)
		$display("test alert done");
		wr(8'h0c, 16'h0101);
		idle();
		wait_poll(7);
		`CHK("round pause", 1'b1, (last_gap >= 300 && last_gap <= 420))
		$display("test pause done");
		give_verdict();
	end
endmodule : tb_top
